// ===== design/uspm_params.svh
`ifndef USPM_PARAMS_SVH
`define USPM_PARAMS_SVH
`define USPM_CLK_HZ 125000000
`define USPM_IDLE_SEC 30
`define USPM_IDLE_CYCLES (64'(`USPM_IDLE_SEC) * 64'(`USPM_CLK_HZ))
`define USPM_PUMP_NS 45000
`define USPM_PUMP_CYCLES ((`USPM_PUMP_NS * 125 + 999) / 1000)
`define USPM_OSC_CYCLES 64
`define USPM_WAKE_CODE 4'h1
`define USPM_SLEEP_EN_BIT 4
`define USPM_MODEM_BITS 4
`endif

// ===== design/uspm_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module uspm_pin_sync (
    input wire logic mclk,
    input wire logic rst,
    uspm_sync_if.sync pins
);
    logic [6:0] stage1;
    logic [6:0] stage2;

    // ==========================================
    // Two-flop synchronisers
    always_ff @(posedge mclk) begin
        if (rst) begin
            stage1 <= 7'h00;
            stage2 <= 7'h00;
        end else begin
            stage1 <= {pins.power_save_raw, pins.autosleep_raw, pins.modem_raw, pins.rx_raw};
            stage2 <= stage1;
        end
    end

    assign pins.rx = stage2[0];
    assign pins.modem = stage2[4:1];
    assign pins.autosleep = stage2[5];
    assign pins.power_save = stage2[6];
endmodule
`default_nettype wire

// ===== design/uspm_pkg.sv
package uspm_pkg;
    typedef enum logic [1:0] {
        USPM_ACTIVE = 2'b00,
        USPM_SLEEP = 2'b01,
        USPM_WAKING = 2'b10
    } uspm_osc_state_type;
    typedef enum logic [1:0] {
        USPM_PUMP_ON = 2'b00,
        USPM_PUMP_OFF = 2'b01,
        USPM_PUMP_START = 2'b10
    } uspm_pump_state_type;
endpackage

// ===== design/uspm_power_manager.sv
// How it works
// R1 - Sleep needs no pending interrupt, nonzero divisor, enable bit, quiet modem, RX low.
// R2 - Autosleep pin low keeps the charge pump always running.
// R3 - Sleeping UART stops the oscillator; no crystal output.
// R4 - Wake on RX start edge, transmit write, or modem status bit set.
// R5 - Wake raises interrupt code 0x1; reading source register clears it.
// R6 - Sleep re-entered once all interrupts clear; never while one pends.
// R7 - Host reads modem status to clear change bits before sleep again.
// R8 - Sleep stays armed until host clears enable bit 4.
// R9 - Autosleep high, awake, idle thirty seconds: charge pump shuts down.
// R10 - Pump off tri-states drivers; receivers and registers stay active.
// R11 - Pump wakes on RX edge, transmit write, modem rise; ready 45 us.
// R12 - Full sleep when asleep and autosleep high; left on pin low or restart.
// R13 - Power-save pin high while asleep isolates host bus inputs.
// R14 - In power-save only RX edge or modem status bit wakes.
// R15 - Power-save re-armed after interrupts clear; held until enable or pin drop.
// R16 - Power-save wake interrupt only after oscillator is ready.
// R17 - Wake event held pending until source register is read.
`timescale 1ns/10ps
`default_nettype none
`include "uspm_params.svh"
module uspm_power_manager
    import uspm_pkg::*;
#(
    parameter longint IDLE_CYCLES = `USPM_IDLE_CYCLES,
    parameter int PUMP_CYCLES = `USPM_PUMP_CYCLES,
    parameter int OSC_CYCLES = `USPM_OSC_CYCLES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic rx_pin,
    input wire logic [3:0] modem_pin,
    input wire logic charge_pump_autosleep_pin,
    input wire logic power_save_pin,
    input wire logic int_pending,
    input wire logic [15:0] divisor,
    input wire logic [7:0] interrupt_enable_register,
    input wire logic [3:0] modem_status,
    input wire logic tx_active,
    input wire logic host_thr_write,
    input wire logic host_isr_read,
    output logic osc_enable,
    output logic crystal_output_pin,
    output logic uart_asleep,
    output logic full_sleep,
    output logic power_save,
    output logic bus_isolate,
    output logic thr_write_taken,
    output logic isr_read_taken,
    output logic charge_pump_on,
    output logic driver_oe_n,
    output logic pump_ready,
    output logic wake_int,
    output logic [3:0] wake_int_code
);
    uspm_sync_if pins();
    uspm_osc_state_type osc_state;
    uspm_pump_state_type pump_state;
    logic rx_prev;
    logic [3:0] modem_prev;
    logic rx_edge;
    logic modem_rise;
    logic sleep_ok;
    logic osc_wake;
    logic pump_wake;
    logic idle_now;
    logic [31:0] idle_count;
    logic [31:0] pump_count;
    logic [15:0] osc_count;
    logic wake_pending;
    logic ps_armed;
    logic osc_div;

    assign pins.rx_raw = rx_pin;
    assign pins.modem_raw = modem_pin;
    assign pins.autosleep_raw = charge_pump_autosleep_pin;
    assign pins.power_save_raw = power_save_pin;

    uspm_pin_sync u_sync (
        .mclk(mclk),
        .rst(rst),
        .pins(pins)
    );

    // ==========================================
    // Edge detection
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_prev <= 1'b0;
            modem_prev <= 4'h0;
        end else begin
            rx_prev <= pins.rx;
            modem_prev <= pins.modem;
        end
    end

    assign rx_edge = pins.rx & ~rx_prev;
    assign modem_rise = |(pins.modem & ~modem_prev);

    // R1 sleep entry conditions
    // R6 R7 R8 no pending interrupt or modem change
    assign sleep_ok = ~int_pending & ~wake_pending & (divisor != 16'h0000)
        & interrupt_enable_register[`USPM_SLEEP_EN_BIT]
        & (modem_status == 4'h0) & ~pins.rx;

    // R4 wake events
    // R14 host write ignored in power-save
    assign osc_wake = rx_edge | (|modem_status)
        | (host_thr_write & ~power_save);

    // ==========================================
    // Oscillator sleep machine
    always_ff @(posedge mclk) begin
        if (rst) begin
            osc_state <= USPM_ACTIVE;
            osc_count <= 16'h0000;
        end else begin
            unique case (osc_state)
                USPM_ACTIVE: begin
                    if (sleep_ok) begin
                        osc_state <= USPM_SLEEP;
                    end
                end
                USPM_SLEEP: begin
                    if (osc_wake) begin
                        osc_state <= USPM_WAKING;
                        osc_count <= 16'h0000;
                    end
                end
                USPM_WAKING: begin
                    // R16 wait for oscillator ready
                    if (osc_count >= 16'(OSC_CYCLES - 1)) begin
                        osc_state <= USPM_ACTIVE;
                    end else begin
                        osc_count <= osc_count + 16'h0001;
                    end
                end
                default: begin
                    osc_state <= USPM_ACTIVE;
                end
            endcase
        end
    end

    // R3 stop crystal while asleep
    assign uart_asleep = (osc_state == USPM_SLEEP);
    assign osc_enable = ~uart_asleep;

    always_ff @(posedge mclk) begin
        if (rst) begin
            osc_div <= 1'b0;
        end else begin
            osc_div <= osc_enable ? ~osc_div : 1'b0;
        end
    end
    assign crystal_output_pin = osc_div;

    // ==========================================
    // Wake interrupt
    // R5 R17 pending until source read; set wins over clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_pending <= 1'b0;
        end else if (osc_state == USPM_WAKING && osc_count >= 16'(OSC_CYCLES - 1)) begin
            wake_pending <= 1'b1;
        end else if (host_isr_read) begin
            wake_pending <= 1'b0;
        end
    end
    assign wake_int = wake_pending;
    // R5 wake code only if nothing else pends
    assign wake_int_code = (wake_pending & ~int_pending) ? `USPM_WAKE_CODE : 4'h0;

    // ==========================================
    // Power-save isolation
    // R15 armed while enable bit and pin high
    assign ps_armed = pins.power_save & interrupt_enable_register[`USPM_SLEEP_EN_BIT];
    // R13 isolate host bus while asleep
    assign power_save = ps_armed & uart_asleep;
    assign bus_isolate = power_save;
    assign thr_write_taken = host_thr_write & ~power_save;
    assign isr_read_taken = host_isr_read & ~power_save;

    // ==========================================
    // Charge pump
    // R9 idle test
    assign idle_now = ~tx_active & ~pins.rx & (pins.modem == 4'h0);
    // R11 pump wake events
    assign pump_wake = rx_edge | modem_rise | thr_write_taken;

    always_ff @(posedge mclk) begin
        if (rst || !idle_now || pump_state != USPM_PUMP_ON) begin
            idle_count <= 32'h0;
        end else if (idle_count < 32'(IDLE_CYCLES)) begin
            idle_count <= idle_count + 32'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            pump_state <= USPM_PUMP_ON;
            pump_count <= 32'h0;
        end else if (!pins.autosleep) begin
            // R2 pump forced on
            // R12 full sleep left on pin low
            pump_state <= USPM_PUMP_ON;
            pump_count <= 32'h0;
        end else begin
            unique case (pump_state)
                USPM_PUMP_ON: begin
                    // R9 idle shutdown
                    // R12 full sleep when asleep
                    if (uart_asleep || idle_count >= 32'(IDLE_CYCLES)) begin
                        pump_state <= USPM_PUMP_OFF;
                    end
                end
                USPM_PUMP_OFF: begin
                    // R11 wake, R12 leave on oscillator restart
                    if (pump_wake || (osc_wake && uart_asleep)) begin
                        pump_state <= USPM_PUMP_START;
                        pump_count <= 32'h0;
                    end
                end
                USPM_PUMP_START: begin
                    // R11 restore after start-up time
                    if (pump_count >= 32'(PUMP_CYCLES - 1)) begin
                        pump_state <= USPM_PUMP_ON;
                    end else begin
                        pump_count <= pump_count + 32'h1;
                    end
                end
                default: begin
                    pump_state <= USPM_PUMP_ON;
                end
            endcase
        end
    end

    assign charge_pump_on = (pump_state != USPM_PUMP_OFF);
    assign pump_ready = (pump_state == USPM_PUMP_ON);
    // R10 drivers tri-stated while pump not ready
    assign driver_oe_n = ~pump_ready;
    assign full_sleep = uart_asleep & (pump_state == USPM_PUMP_OFF);
endmodule
`default_nettype wire

// ===== design/uspm_sync_if.sv
`timescale 1ns/10ps
`default_nettype none
interface uspm_sync_if;
    logic rx_raw;
    logic [3:0] modem_raw;
    logic autosleep_raw;
    logic power_save_raw;
    logic rx;
    logic [3:0] modem;
    logic autosleep;
    logic power_save;
    modport sync (input rx_raw, modem_raw, autosleep_raw, power_save_raw,
        output rx, modem, autosleep, power_save);
    modport core (output rx_raw, modem_raw, autosleep_raw, power_save_raw,
        input rx, modem, autosleep, power_save);
endinterface
`default_nettype wire

// ===== testbench/test_uart_sleep_power_manager.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// Bench
module test_uart_sleep_power_manager
    import uspm_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic rx_pin = 1'b0;
    logic [3:0] modem_pin = 4'h0;
    logic charge_pump_autosleep_pin = 1'b0;
    logic power_save_pin = 1'b0;
    logic int_pending = 1'b1;
    logic [15:0] divisor = 16'h0001;
    logic [7:0] interrupt_enable_register = 8'h10;
    logic tx_active = 1'b0;
    logic host_thr_write = 1'b0;
    logic [3:0] modem_set = 4'h0;
    logic slow = 1'b1;
    logic [3:0] modem_status, wake_int_code;
    logic host_isr_read, osc_enable, crystal_output_pin, uart_asleep, full_sleep, power_save;
    logic bus_isolate, thr_write_taken, isr_read_taken, charge_pump_on, driver_oe_n;
    logic pump_ready, wake_int;
    logic xtal_seen;
    int n_mismatch = 0;
    int samples_checked = 0;
    string nm[8] = '{"asleep", "wake_int", "pump_on", "ready", "osc", "psave", "full", "oe_n"};
    always #4 mclk = ~mclk;
    uspm_power_manager #(.IDLE_CYCLES(50), .PUMP_CYCLES(10), .OSC_CYCLES(4)) i_dut (.mclk,
        .rst, .rx_pin, .modem_pin, .charge_pump_autosleep_pin, .power_save_pin, .int_pending,
        .divisor, .interrupt_enable_register, .modem_status, .tx_active, .host_thr_write,
        .host_isr_read, .osc_enable, .crystal_output_pin, .uart_asleep, .full_sleep,
        .power_save, .bus_isolate, .thr_write_taken, .isr_read_taken, .charge_pump_on,
        .driver_oe_n, .pump_ready, .wake_int, .wake_int_code);
    uspm_host_model i_host (.mclk, .rst, .modem_set, .slow, .wake_int, .modem_status,
        .host_isr_read);
    function automatic logic pick(input int s);
        logic [7:0] v;
        v = {driver_oe_n, full_sleep, power_save, osc_enable, pump_ready, charge_pump_on,
            wake_int, uart_asleep};
        return v[s];
    endfunction
    task automatic check(input string n, input logic [3:0] seen, input logic [3:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic st(input int s, input logic v, input int n);
        cyc(n);
        #1;
        check(nm[s], {3'h0, pick(s)}, {3'h0, v});
        @(posedge mclk);
    endtask
    task automatic wt(input int s, input logic v);
        int i;
        #1;
        for (i = 0; i < 200 && pick(s) !== v; i++) begin
            @(posedge mclk);
            #1;
        end
        check(nm[s], {3'h0, pick(s)}, {3'h0, v});
        @(posedge mclk);
    endtask
    task automatic close_out;
        $display("Mismatches %0d in %0d checks", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        cyc(20000);
        n_mismatch++;
        close_out();
    end
    initial begin
        cyc(5);
        rst <= 1'b0;
        st(0, 1'b0, 20);
        #1 xtal_seen = crystal_output_pin;
        cyc(1);
        #1 check("xtal", {3'h0, crystal_output_pin}, {3'h0, ~xtal_seen});
        cyc(1);
        int_pending <= 1'b0;
        divisor <= 16'h0000;
        st(0, 1'b0, 20);
        divisor <= 16'h0100;
        wt(0, 1'b1);
        st(4, 1'b0, 3);
        modem_set <= 4'h8;
        cyc(1);
        modem_set <= 4'h0;
        wt(1, 1'b1);
        #1 check("code", wake_int_code, 4'h1);
        cyc(1);
        int_pending <= 1'b1;
        cyc(1);
        #1 check("code", wake_int_code, 4'h0);
        cyc(1);
        int_pending <= 1'b0;
        slow <= 1'b0;
        wt(1, 1'b0);
        wt(0, 1'b1);
        host_thr_write <= 1'b1;
        cyc(1);
        host_thr_write <= 1'b0;
        wt(1, 1'b1);
        wt(0, 1'b1);
        rx_pin <= 1'b1;
        wt(0, 1'b0);
        rx_pin <= 1'b0;
        wt(0, 1'b1);
        power_save_pin <= 1'b1;
        wt(5, 1'b1);
        host_thr_write <= 1'b1;
        cyc(1);
        host_thr_write <= 1'b0;
        st(0, 1'b1, 20);
        modem_set <= 4'h1;
        cyc(1);
        modem_set <= 4'h0;
        wt(1, 1'b1);
        wt(5, 1'b1);
        power_save_pin <= 1'b0;
        charge_pump_autosleep_pin <= 1'b1;
        wt(6, 1'b1);
        wt(2, 1'b0);
        rx_pin <= 1'b1;
        wt(6, 1'b0);
        wt(3, 1'b1);
        st(0, 1'b0, 5);
        rx_pin <= 1'b0;
        interrupt_enable_register <= 8'h00;
        wt(2, 1'b0);
        st(7, 1'b1, 1);
        st(0, 1'b0, 1);
        modem_pin <= 4'h2;
        st(3, 1'b0, 3);
        wt(3, 1'b1);
        modem_pin <= 4'h0;
        tx_active <= 1'b1;
        st(2, 1'b1, 80);
        tx_active <= 1'b0;
        charge_pump_autosleep_pin <= 1'b0;
        st(2, 1'b1, 80);
        close_out();
    end
endmodule
`default_nettype wire

// ===== testbench/uspm_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// Port checks
module uspm_checker
    import uspm_pkg::*;
#(
    parameter int OSC_CYCLES = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic charge_pump_autosleep_pin,
    input wire logic int_pending,
    input wire logic [15:0] divisor,
    input wire logic [7:0] interrupt_enable_register,
    input wire logic [3:0] modem_status,
    input wire logic osc_enable,
    input wire logic crystal_output_pin,
    input wire logic uart_asleep,
    input wire logic full_sleep,
    input wire logic power_save,
    input wire logic bus_isolate,
    input wire logic thr_write_taken,
    input wire logic isr_read_taken,
    input wire logic charge_pump_on,
    input wire logic driver_oe_n,
    input wire logic wake_int,
    input wire logic [3:0] wake_int_code
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_sleep_conds: assert property ($rose(uart_asleep) |-> !$past(int_pending)
        && $past(divisor) != 16'h0 && $past(interrupt_enable_register[4])
        && $past(modem_status) == 4'h0 && !$past(wake_int)) else $error("early sleep");
    a_osc_stopped: assert property (uart_asleep && $past(uart_asleep) && $past(uart_asleep, 2)
        |-> !osc_enable && !crystal_output_pin) else $error("clock while asleep");
    a_code_value: assert property (wake_int_code != 4'h0
        |-> wake_int_code == 4'h1 && wake_int && !int_pending) else $error("bad wake code");
    a_read_clears: assert property (wake_int && isr_read_taken |=> !wake_int)
        else $error("wake int not cleared");
    a_int_osc_ready: assert property ($rose(wake_int)
        |-> $past(osc_enable, OSC_CYCLES - 1) && $past(osc_enable)) else $error("int too soon");
    a_bus_isolated: assert property (power_save |-> bus_isolate && uart_asleep
        && !thr_write_taken && !isr_read_taken) else $error("bus not isolated");
    a_pump_drivers: assert property (!charge_pump_on |-> driver_oe_n)
        else $error("drivers on, pump off");
    a_pump_pin: assert property ($fell(charge_pump_on) |-> $past(charge_pump_autosleep_pin, 2)
        || $past(charge_pump_autosleep_pin, 3) || $past(charge_pump_autosleep_pin, 4))
        else $error("pump off, pin low");
    a_full_asleep: assert property (full_sleep |-> uart_asleep && !osc_enable)
        else $error("full sleep while awake");
endmodule
bind uspm_power_manager uspm_checker #(.OSC_CYCLES(OSC_CYCLES)) u_chk (.mclk, .rst,
    .charge_pump_autosleep_pin, .int_pending, .divisor, .interrupt_enable_register,
    .modem_status, .osc_enable, .crystal_output_pin, .uart_asleep, .full_sleep, .power_save,
    .bus_isolate, .thr_write_taken, .isr_read_taken, .charge_pump_on, .driver_oe_n,
    .wake_int, .wake_int_code);
`default_nettype wire

// ===== testbench/uspm_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// Host that services the wake interrupt
module uspm_host_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] modem_set,
    input wire logic slow,
    input wire logic wake_int,
    output logic [3:0] modem_status,
    output logic host_isr_read
);
    always_ff @(posedge mclk) begin
        if (rst) begin
            modem_status <= 4'h0;
            host_isr_read <= 1'b0;
        end else begin
            host_isr_read <= wake_int && !slow && !host_isr_read;
            if (host_isr_read) begin
                modem_status <= 4'h0;
            end else begin
                modem_status <= modem_status | modem_set;
            end
        end
    end
endmodule
`default_nettype wire
